/* File: verilog/nvmcl_top.v */
// Start-up configuration loader with host register port
`timescale 1ns/10ps
module nvmcl_top #(
    // Arbitrary value, stands for the customer key
    parameter [15:0] CUSTOMER_KEY = 16'h5a3c
) (
    input  wire        CORE_CLK,
    input  wire        RST,
    input  wire        POWER_ON_RST,
    input  wire [7:0]  REG_ADDR,
    input  wire        REG_WR,
    input  wire [7:0]  REG_WDATA,
    input  wire        REG_RD,
    output reg  [7:0]  REG_RDATA,
    output reg         REG_RVALID,
    input  wire        PROG_REQ,
    input  wire [15:0] PROG_KEY,
    input  wire [71:0] PROG_IMAGE,
    output reg         PROG_ACK,
    output reg         PROG_REFUSED,
    output wire        NVM_LOCKED,
    input  wire        MAIN_SUPPLY_PRESENT,
    input  wire        SYS_SUPPLY_PRESENT,
    input  wire        SYS_SUPPLY_ABOVE_3V1,
    output wire        SYSTEM_SUPPLY_INPUT_SEL,
    output reg         CONFIG_READY,
    output wire        CONN_ALERT_MASK,
    output wire        MONITOR_ALERT_MASK,
    output wire        FAULT_ALERT_MASK,
    output wire [1:0]  ADVERTISED_CURRENT_SEL,
    output wire        CABLE_POWER_DISCHARGE_ON,
    output wire        CABLE_POWER_SUPPLY_ON,
    output wire [3:0]  CABLE_POWER_CURRENT_LIMIT,
    output wire        CABLE_POWER_MONITOR_ON,
    output wire        CABLE_POWER_UNDERVOLT_SEL,
    output wire [3:0]  BUS_HIGH_LIMIT_SHIFT,
    output wire [3:0]  BUS_LOW_LIMIT_SHIFT,
    output wire        SOFT_RESET_SELECT,
    output wire [3:0]  DISCHARGE_TO_ZERO_TIME,
    output wire [3:0]  DISCHARGE_STEP_TIME,
    output wire        MAIN_SUPPLY_OVERVOLT_OFF,
    output wire        BUS_RANGE_CHECK_OFF,
    output wire [1:0]  BUS_SAFE_ZERO_THRESHOLD,
    output wire        MAIN_SUPPLY_UNDERVOLT_OFF,
    output wire        STANDBY_POWER_OFF,
    output wire        DISCHARGE_PATH_OFF
);
`include "nvmcl_map.vh"

    localparam       S_LOAD = 1'b0;
    localparam       S_RUN  = 1'b1;

    localparam [71:0] NVM_MASK = `NVMCL_NVM_MASK;
    localparam [71:0] WR_MASK  = `NVMCL_WR_MASK;
    localparam [71:0] FACTORY  = `NVMCL_FACTORY_IMAGE;

    reg         state_q;
    reg         state_d;
    reg  [3:0]  load_cnt_q;
    reg  [3:0]  load_cnt_d;
    reg  [71:0] cfg_q;
    reg  [71:0] cfg_d;
    reg  [7:0]  rdata_d;
    reg         ready_d;
    reg         ack_d;
    reg         refused_d;
    reg  [3:0]  load_idx;
    reg  [3:0]  wr_idx;
    reg  [3:0]  rd_idx;
    reg  [7:0]  slot_nvm_mask;
    reg  [7:0]  slot_wr_mask;
    reg  [7:0]  slot_factory;
    reg  [7:0]  slot_load;
    reg  [7:0]  slot_write;
    wire [7:0]  nvm_data;
    wire [3:0]  nvm_rd_index;
    wire        prog_ok;
    wire        nvm_locked;

    // Address to slot; unmapped and stored-only slots give none
    function [3:0] slot_of;
        input [7:0] addr;
        begin
            case (addr)
                `NVMCL_OFS_ALERT_MASK:  slot_of = `NVMCL_IDX_ALERT_MASK;
                `NVMCL_OFS_CC_CAP:      slot_of = `NVMCL_IDX_CC_CAP;
                `NVMCL_OFS_VCONN_ILIM:  slot_of = `NVMCL_IDX_VCONN_ILIM;
                `NVMCL_OFS_VCONN_MON:   slot_of = `NVMCL_IDX_VCONN_MON;
                `NVMCL_OFS_RANGE_SHIFT: slot_of = `NVMCL_IDX_RANGE_SHIFT;
                `NVMCL_OFS_SOFT_RESET:  slot_of = `NVMCL_IDX_SOFT_RESET;
                `NVMCL_OFS_DISCH_TIME:  slot_of = `NVMCL_IDX_DISCH_TIME;
                `NVMCL_OFS_SUPPLY_MON:  slot_of = `NVMCL_IDX_SUPPLY_MON;
                default:                slot_of = `NVMCL_IDX_NONE;
            endcase
        end
    endfunction

    // Bit offset of a slot inside the packed image
    function [6:0] slot_bit;
        input [3:0] idx;
        begin
            slot_bit = {idx, 3'b000};
        end
    endfunction

    // Byte of a slot; slots past the last read zero, never an unknown
    function [7:0] slot_get;
        input [71:0] img;
        input [3:0]  idx;
        begin
            case (idx)
                4'h0:    slot_get = img[7:0];
                4'h1:    slot_get = img[15:8];
                4'h2:    slot_get = img[23:16];
                4'h3:    slot_get = img[31:24];
                4'h4:    slot_get = img[39:32];
                4'h5:    slot_get = img[47:40];
                4'h6:    slot_get = img[55:48];
                4'h7:    slot_get = img[63:56];
                4'h8:    slot_get = img[71:64];
                default: slot_get = 8'h00;
            endcase
        end
    endfunction

    // Image with one slot replaced; other slots pass unchanged
    function [71:0] slot_put;
        input [71:0] img;
        input [3:0]  idx;
        input [7:0]  val;
        begin
            slot_put = img;
            if (idx < `NVMCL_SLOTS) begin
                slot_put[slot_bit(idx) +: 8] = val;
            end
        end
    endfunction

    // Stored image; its read data come out of a register
    nvmcl_nvm_store u_store (
        .clk        (CORE_CLK),
        .por        (POWER_ON_RST),
        .prog_en    (prog_ok),
        .prog_image (PROG_IMAGE),
        .rd_index   (nvm_rd_index),
        .rd_data_q  (nvm_data),
        .locked_q   (nvm_locked)
    );

    // Supply choice runs on synchronised comparator levels
    nvmcl_supply_sel u_supply (
        .clk          (CORE_CLK),
        .rst          (RST),
        .main_present (MAIN_SUPPLY_PRESENT),
        .sys_present  (SYS_SUPPLY_PRESENT),
        .sys_above    (SYS_SUPPLY_ABOVE_3V1),
        .use_sys_q    (SYSTEM_SUPPLY_INPUT_SEL)
    );

    assign NVM_LOCKED   = nvm_locked;
    assign nvm_rd_index = (state_q == S_LOAD) ? load_cnt_q : `NVMCL_IDX_NONE;

    // Refused during load so the image is never rewritten mid-read
    // Key and lock check
    assign prog_ok = PROG_REQ & (state_q == S_RUN) & ~nvm_locked
                   & (PROG_KEY == CUSTOMER_KEY);

    // Load sequencer: one slot issued per cycle, captured a cycle later
    // The store answers a cycle late, so the count runs one past the last slot
    always @* begin
        state_d    = state_q;
        load_cnt_d = load_cnt_q;
        ready_d    = CONFIG_READY;
        load_idx   = load_cnt_q - 4'h1;
        case (state_q)
            S_LOAD: begin
                load_cnt_d = load_cnt_q + 4'h1;
                if (load_cnt_q == `NVMCL_LOAD_LAST) begin
                    state_d    = S_RUN;
                    load_cnt_d = 4'h0;
                    ready_d    = 1'b1;
                end
            end
            S_RUN: begin
                load_cnt_d = 4'h0;
            end
            default: begin
                state_d    = S_LOAD;
                load_cnt_d = 4'h0;
                ready_d    = 1'b0;
            end
        endcase
    end

    // Live configuration update
    always @* begin
        cfg_d         = cfg_q;
        wr_idx        = slot_of(REG_ADDR);
        slot_nvm_mask = slot_get(NVM_MASK, load_idx);
        slot_factory  = slot_get(FACTORY, load_idx);
        slot_wr_mask  = slot_get(WR_MASK, wr_idx);
        slot_load     = (nvm_data & slot_nvm_mask)
                      | (slot_factory & ~slot_nvm_mask);
        slot_write    = (slot_get(cfg_q, wr_idx) & ~slot_wr_mask)
                      | (REG_WDATA & slot_wr_mask);
        if (state_q == S_LOAD) begin
            if (load_cnt_q != 4'h0) begin
                cfg_d = slot_put(cfg_q, load_idx, slot_load);
            end
        end else if (REG_WR && wr_idx != `NVMCL_IDX_NONE) begin
            cfg_d = slot_put(cfg_q, wr_idx, slot_write);
        end
    end

    // Read answer; unmapped offsets and reads during load return zero
    always @* begin
        rd_idx  = slot_of(REG_ADDR);
        rdata_d = 8'h00;
        if (REG_RD && state_q == S_RUN && rd_idx != `NVMCL_IDX_NONE) begin
            rdata_d = slot_get(cfg_q, rd_idx);
        end
    end

    always @* begin
        ack_d     = prog_ok;
        refused_d = PROG_REQ & ~prog_ok;
    end

    // Live bits start at the factory image so outputs are sane during load
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_q      <= S_LOAD;
            load_cnt_q   <= 4'h0;
            cfg_q        <= `NVMCL_FACTORY_IMAGE;
            CONFIG_READY <= 1'b0;
            REG_RDATA    <= 8'h00;
            REG_RVALID   <= 1'b0;
            PROG_ACK     <= 1'b0;
            PROG_REFUSED <= 1'b0;
        end else begin
            state_q      <= state_d;
            load_cnt_q   <= load_cnt_d;
            cfg_q        <= cfg_d;
            CONFIG_READY <= ready_d;
            REG_RDATA    <= rdata_d;
            // Every read strobe is answered, even unmapped or during load
            REG_RVALID   <= REG_RD;
            PROG_ACK     <= ack_d;
            PROG_REFUSED <= refused_d;
        end
    end

    // Field outputs are plain slices of the live flops
    // Alert masks
    assign CONN_ALERT_MASK    = cfg_q[8*0 + `NVMCL_B_CONN_MASK];
    assign MONITOR_ALERT_MASK = cfg_q[8*0 + `NVMCL_B_MON_MASK];
    assign FAULT_ALERT_MASK   = cfg_q[8*0 + `NVMCL_B_FAULT_MASK];

    assign ADVERTISED_CURRENT_SEL   = cfg_q[8*1 + 5 +: 2];
    assign CABLE_POWER_DISCHARGE_ON = cfg_q[8*1 + `NVMCL_B_VCONN_DISCH];
    assign CABLE_POWER_SUPPLY_ON    = cfg_q[8*1 + `NVMCL_B_VCONN_SUPPLY];

    assign CABLE_POWER_CURRENT_LIMIT = cfg_q[8*2 +: 4];

    assign CABLE_POWER_MONITOR_ON    = cfg_q[8*3 + `NVMCL_B_MON_ON];
    assign CABLE_POWER_UNDERVOLT_SEL = cfg_q[8*3 + `NVMCL_B_UV_SEL];

    assign BUS_HIGH_LIMIT_SHIFT = cfg_q[8*4 + 4 +: 4];
    assign BUS_LOW_LIMIT_SHIFT  = cfg_q[8*4 +: 4];

    assign SOFT_RESET_SELECT = cfg_q[8*5 + `NVMCL_B_SOFT_RST_SEL];

    assign DISCHARGE_TO_ZERO_TIME = cfg_q[8*6 + 4 +: 4];
    assign DISCHARGE_STEP_TIME    = cfg_q[8*6 +: 4];

    assign MAIN_SUPPLY_OVERVOLT_OFF  = cfg_q[8*7 + `NVMCL_B_OV_OFF];
    assign BUS_RANGE_CHECK_OFF       = cfg_q[8*7 + `NVMCL_B_RANGE_OFF];
    assign BUS_SAFE_ZERO_THRESHOLD   = cfg_q[8*7 + 2 +: 2];
    assign MAIN_SUPPLY_UNDERVOLT_OFF = cfg_q[8*7 + `NVMCL_B_UV_OFF];

    // Stored-only bits have no register address at all
    // Standby and discharge-path disables
    assign STANDBY_POWER_OFF  = cfg_q[8*8 + `NVMCL_B_STANDBY_OFF];
    assign DISCHARGE_PATH_OFF = cfg_q[8*8 + `NVMCL_B_DISCH_OFF];

endmodule // nvmcl_top

/* File: verilog/nvmcl_map.vh */
// Constants for the start-up configuration loader
`ifndef NVMCL_MAP_VH
`define NVMCL_MAP_VH

// Register offsets
`define NVMCL_OFS_ALERT_MASK   8'h0c
`define NVMCL_OFS_CC_CAP       8'h18
`define NVMCL_OFS_VCONN_ILIM   8'h1e
`define NVMCL_OFS_VCONN_MON    8'h20
`define NVMCL_OFS_RANGE_SHIFT  8'h22
`define NVMCL_OFS_SOFT_RESET   8'h23
`define NVMCL_OFS_DISCH_TIME   8'h25
`define NVMCL_OFS_SUPPLY_MON   8'h2e

// Image slots, one byte each; slot 8 holds the stored-only bits
`define NVMCL_IDX_ALERT_MASK   4'h0
`define NVMCL_IDX_CC_CAP       4'h1
`define NVMCL_IDX_VCONN_ILIM   4'h2
`define NVMCL_IDX_VCONN_MON    4'h3
`define NVMCL_IDX_RANGE_SHIFT  4'h4
`define NVMCL_IDX_SOFT_RESET   4'h5
`define NVMCL_IDX_DISCH_TIME   4'h6
`define NVMCL_IDX_SUPPLY_MON   4'h7
`define NVMCL_IDX_NVM_ONLY     4'h8
`define NVMCL_IDX_NONE         4'hf
`define NVMCL_SLOTS            9
`define NVMCL_LOAD_LAST        4'h9

// Field positions
`define NVMCL_B_CONN_MASK      6
`define NVMCL_B_MON_MASK       5
`define NVMCL_B_FAULT_MASK     4
`define NVMCL_F_ADV_CUR        6:5
`define NVMCL_B_VCONN_DISCH    4
`define NVMCL_B_VCONN_SUPPLY   0
`define NVMCL_F_ILIM           3:0
`define NVMCL_B_MON_ON         0
`define NVMCL_B_UV_SEL         1
`define NVMCL_F_HIGH_SHIFT     7:4
`define NVMCL_F_LOW_SHIFT      3:0
`define NVMCL_B_SOFT_RST_SEL   0
`define NVMCL_F_TO_ZERO        7:4
`define NVMCL_F_STEP           3:0
`define NVMCL_B_UV_OFF         0
`define NVMCL_B_RANGE_OFF      1
`define NVMCL_F_SAFE_ZERO      3:2
`define NVMCL_B_OV_OFF         3
`define NVMCL_B_STANDBY_OFF    0
`define NVMCL_B_DISCH_OFF      1

// Factory image, slot 0 in the low byte
`define NVMCL_FACTORY_IMAGE    72'h01_01aa_0055_0100_2170
// Bits taken from the stored image at load
`define NVMCL_NVM_MASK         72'h03_1fff_00ff_000f_7170
// Bits software may write
`define NVMCL_WR_MASK          72'h00_1fff_01ff_030f_7170

// System supply switch-over level, in millivolts
`define NVMCL_SYS_SUPPLY_MV    3100

`endif

/* File: verilog/nvmcl_nvm_store.v */
// One-time programmable store of the start-up image
`timescale 1ns/10ps
module nvmcl_nvm_store (
    input  wire        clk,
    input  wire        por,
    input  wire        prog_en,
    input  wire [71:0] prog_image,
    input  wire [3:0]  rd_index,
    output reg  [7:0]  rd_data_q,
    output reg         locked_q
);
`include "nvmcl_map.vh"

    reg  [71:0] image_q;
    wire [6:0]  rd_bit;

    assign rd_bit = {rd_index[3:0], 3'b000};

    // Only power-on clears the array, a pin reset keeps it
    always @(posedge clk or posedge por) begin
        if (por) begin
            image_q   <= `NVMCL_FACTORY_IMAGE;
            locked_q  <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            if (prog_en && !locked_q) begin
                image_q  <= prog_image;
                locked_q <= 1'b1;
            end
            if (rd_index < `NVMCL_SLOTS) begin
                rd_data_q <= image_q[rd_bit +: 8];
            end else begin
                rd_data_q <= 8'h00;
            end
        end
    end

endmodule // nvmcl_nvm_store

/* File: verilog/nvmcl_supply_sel.v */
// Choice of the supply that powers the device
`timescale 1ns/10ps
module nvmcl_supply_sel (
    input  wire clk,
    input  wire rst,
    input  wire main_present,
    input  wire sys_present,
    input  wire sys_above,
    output reg  use_sys_q
);
`include "nvmcl_map.vh"

    reg  [2:0] meta_q;
    reg  [2:0] sync_q;
    wire       use_sys_d;

    // Comparator pins are asynchronous, two flops each
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= {sys_above, sys_present, main_present};
            sync_q <= meta_q;
        end
    end

    assign use_sys_d = sync_q[1] & (sync_q[2] | ~sync_q[0]);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            use_sys_q <= 1'b0;
        end else begin
            use_sys_q <= use_sys_d;
        end
    end

endmodule // nvmcl_supply_sel

/* File: bench/nvmcl_props.sv */
// Checker of the loader's port behaviour
`timescale 1ns/10ps
module nvmcl_props #(
    parameter [15:0] CUSTOMER_KEY = 16'h5a3c
) (
    input wire        CORE_CLK,
    input wire        RST,
    input wire        POWER_ON_RST,
    input wire [7:0]  REG_ADDR,
    input wire        REG_WR,
    input wire [7:0]  REG_WDATA,
    input wire        REG_RD,
    input wire        REG_RVALID,
    input wire        PROG_REQ,
    input wire [15:0] PROG_KEY,
    input wire        PROG_ACK,
    input wire        PROG_REFUSED,
    input wire        NVM_LOCKED,
    input wire        MAIN_SUPPLY_PRESENT,
    input wire        SYS_SUPPLY_PRESENT,
    input wire        SYS_SUPPLY_ABOVE_3V1,
    input wire        SYSTEM_SUPPLY_INPUT_SEL,
    input wire        CONFIG_READY,
    input wire [3:0]  BUS_HIGH_LIMIT_SHIFT,
    input wire [3:0]  BUS_LOW_LIMIT_SHIFT,
    input wire        STANDBY_POWER_OFF,
    input wire        DISCHARGE_PATH_OFF
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Expected supply choice; the synchroniser needs a few stable cycles
    wire want_sys = SYS_SUPPLY_PRESENT & (SYS_SUPPLY_ABOVE_3V1 | ~MAIN_SUPPLY_PRESENT);

    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read strobe got no valid answer");
    a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("read answer without a read strobe");
    a_prog_one_answer: assert property (PROG_REQ |=> PROG_ACK != PROG_REFUSED)
        else $error("programming request not answered exactly once");
    a_bad_key_refused: assert property (PROG_REQ && PROG_KEY != CUSTOMER_KEY
        |=> PROG_REFUSED)
        else $error("wrong key was not refused");
    a_locked_refused: assert property (PROG_REQ && NVM_LOCKED |=> PROG_REFUSED)
        else $error("second programming was not refused");
    a_accept_locks: assert property (PROG_ACK |-> NVM_LOCKED)
        else $error("accepted programming left the store unlocked");
    a_lock_holds: assert property (disable iff (RST || POWER_ON_RST)
        NVM_LOCKED |=> NVM_LOCKED)
        else $error("store lock dropped without power-on reset");
    a_load_time: assert property ($fell(RST) |-> !CONFIG_READY [*7] ##[1:4] CONFIG_READY)
        else $error("load did not finish in its cycle budget");
    a_ready_holds: assert property (CONFIG_READY |=> CONFIG_READY)
        else $error("ready dropped without reset");
    a_supply_follow: assert property ($stable(want_sys) [*5]
        |-> SYSTEM_SUPPLY_INPUT_SEL == want_sys)
        else $error("supply choice does not follow the inputs");
    a_shift_write: assert property (REG_WR && CONFIG_READY && REG_ADDR == 8'h22
        |=> {BUS_HIGH_LIMIT_SHIFT, BUS_LOW_LIMIT_SHIFT} == $past(REG_WDATA))
        else $error("shift field write not in force next cycle");
    a_stored_fixed: assert property (CONFIG_READY
        |=> $stable({STANDBY_POWER_OFF, DISCHARGE_PATH_OFF}))
        else $error("stored-only bits changed in operation");

    c_prog_ack: cover property (PROG_ACK);
    c_prog_refused: cover property (PROG_REFUSED);
    c_shift_read: cover property (REG_RD && REG_ADDR == 8'h22 ##1 REG_RVALID);
endmodule // nvmcl_props

bind nvmcl_top nvmcl_props #(.CUSTOMER_KEY(CUSTOMER_KEY)) u_props (
    .CORE_CLK(CORE_CLK), .RST(RST), .POWER_ON_RST(POWER_ON_RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RVALID(REG_RVALID),
    .PROG_REQ(PROG_REQ), .PROG_KEY(PROG_KEY), .PROG_ACK(PROG_ACK), .PROG_REFUSED(PROG_REFUSED),
    .NVM_LOCKED(NVM_LOCKED), .MAIN_SUPPLY_PRESENT(MAIN_SUPPLY_PRESENT),
    .SYS_SUPPLY_PRESENT(SYS_SUPPLY_PRESENT), .SYS_SUPPLY_ABOVE_3V1(SYS_SUPPLY_ABOVE_3V1),
    .SYSTEM_SUPPLY_INPUT_SEL(SYSTEM_SUPPLY_INPUT_SEL), .CONFIG_READY(CONFIG_READY),
    .BUS_HIGH_LIMIT_SHIFT(BUS_HIGH_LIMIT_SHIFT), .BUS_LOW_LIMIT_SHIFT(BUS_LOW_LIMIT_SHIFT),
    .STANDBY_POWER_OFF(STANDBY_POWER_OFF), .DISCHARGE_PATH_OFF(DISCHARGE_PATH_OFF)
);

/* File: bench/nvmcl_host.sv */
// Host processor model on the register and programming port
`timescale 1ns/10ps
module nvmcl_host (
    input  wire        clk,
    input  wire [7:0]  rdata,
    input  wire        rvalid,
    input  wire        ack,
    input  wire        refused,
    output reg  [7:0]  addr,
    output reg         wr,
    output reg  [7:0]  wdata,
    output reg         rd,
    output reg         req,
    output reg  [15:0] key,
    output reg  [71:0] image
);
    initial begin
        {addr, wr, wdata, rd, req, key, image} = 0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        // Released lines show the inverse so stale values never match
        {addr, wdata, wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        {addr, rd} = {~a, 1'b0};
        {d, v} = {rdata, rvalid};
    endtask
    task automatic prog(input logic [15:0] k, input logic [71:0] im, output logic [1:0] res);
        @(negedge clk);
        {key, image, req} = {k, im, 1'b1};
        @(negedge clk);
        {key, image, req} = {~k, ~im, 1'b0};
        res = {ack, refused};
    endtask
endmodule // nvmcl_host

/* File: bench/tb_top.sv */
// Self-checking bench of the start-up configuration loader
`timescale 1ns/10ps
module tb_top;
    logic        CORE_CLK, RST, POWER_ON_RST;
    logic        MAIN_SUPPLY_PRESENT, SYS_SUPPLY_PRESENT, SYS_SUPPLY_ABOVE_3V1;
    wire  [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
    wire         REG_WR, REG_RD, REG_RVALID, PROG_REQ, PROG_ACK, PROG_REFUSED, NVM_LOCKED;
    wire  [15:0] PROG_KEY;
    wire  [71:0] PROG_IMAGE;
    wire         SYSTEM_SUPPLY_INPUT_SEL, CONFIG_READY;
    wire  [36:0] flds;
    logic [7:0]  offs [9] = '{8'h0c, 8'h18, 8'h1e, 8'h20, 8'h22, 8'h23, 8'h25, 8'h2e, 8'h00};
    logic [7:0]  fac [9] = '{8'h70, 8'h21, 8'h00, 8'h01, 8'h55, 8'h00, 8'haa, 8'h01, 8'h01};
    logic [7:0]  wm [9] = '{8'h70, 8'h71, 8'h0f, 8'h03, 8'hff, 8'h01, 8'hff, 8'h1f, 8'h00};
    logic [7:0]  nm [9] = '{8'h70, 8'h71, 8'h0f, 8'h00, 8'hff, 8'h00, 8'hff, 8'h1f, 8'h03};
    logic [7:0]  e [9];
    logic [7:0]  d;
    logic        v;
    logic [1:0]  res;
    int          errors, check_count, cycles;

    nvmcl_top DUT (
        .CORE_CLK(CORE_CLK), .RST(RST), .POWER_ON_RST(POWER_ON_RST), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .PROG_REQ(PROG_REQ), .PROG_KEY(PROG_KEY),
        .PROG_IMAGE(PROG_IMAGE), .PROG_ACK(PROG_ACK), .PROG_REFUSED(PROG_REFUSED),
        .NVM_LOCKED(NVM_LOCKED), .MAIN_SUPPLY_PRESENT(MAIN_SUPPLY_PRESENT),
        .SYS_SUPPLY_PRESENT(SYS_SUPPLY_PRESENT), .SYS_SUPPLY_ABOVE_3V1(SYS_SUPPLY_ABOVE_3V1),
        .SYSTEM_SUPPLY_INPUT_SEL(SYSTEM_SUPPLY_INPUT_SEL), .CONFIG_READY(CONFIG_READY),
        .CONN_ALERT_MASK(flds[36]), .MONITOR_ALERT_MASK(flds[35]), .FAULT_ALERT_MASK(flds[34]),
        .ADVERTISED_CURRENT_SEL(flds[33:32]), .CABLE_POWER_DISCHARGE_ON(flds[31]),
        .CABLE_POWER_SUPPLY_ON(flds[30]), .CABLE_POWER_CURRENT_LIMIT(flds[29:26]),
        .CABLE_POWER_MONITOR_ON(flds[25]), .CABLE_POWER_UNDERVOLT_SEL(flds[24]),
        .BUS_HIGH_LIMIT_SHIFT(flds[23:20]), .BUS_LOW_LIMIT_SHIFT(flds[19:16]),
        .SOFT_RESET_SELECT(flds[15]), .DISCHARGE_TO_ZERO_TIME(flds[14:11]),
        .DISCHARGE_STEP_TIME(flds[10:7]), .MAIN_SUPPLY_OVERVOLT_OFF(flds[6]),
        .BUS_RANGE_CHECK_OFF(flds[5]), .BUS_SAFE_ZERO_THRESHOLD(flds[4:3]),
        .MAIN_SUPPLY_UNDERVOLT_OFF(flds[2]), .STANDBY_POWER_OFF(flds[1]),
        .DISCHARGE_PATH_OFF(flds[0])
    );
    nvmcl_host host (
        .clk(CORE_CLK), .rdata(REG_RDATA), .rvalid(REG_RVALID), .ack(PROG_ACK),
        .refused(PROG_REFUSED), .addr(REG_ADDR), .wr(REG_WR), .wdata(REG_WDATA), .rd(REG_RD),
        .req(PROG_REQ), .key(PROG_KEY), .image(PROG_IMAGE)
    );

    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // Generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [36:0] fexp();
        return {e[0][6:4], e[1][6:4], e[1][0], e[2][3:0], e[3][0], e[3][1], e[4], e[5][0], e[6],
                e[7][3], e[7][1], e[7][3:2], e[7][0], e[8][0], e[8][1]};
    endfunction
    task automatic wait_ready();
        for (int n = 0; n < 20 && CONFIG_READY !== 1'b1; n++) @(negedge CORE_CLK);
        chk("ready", 37'h1, CONFIG_READY);
    endtask
    task automatic pin_reset();
        @(negedge CORE_CLK);
        RST = 1'b1;
        @(negedge CORE_CLK);
        RST = 1'b0;
        wait_ready();
    endtask
    // Fields on the pins, then every register read back through the port
    task automatic check_all();
        chk("fields", fexp(), flds);
        for (int i = 0; i < 8; i++) begin
            host.rd_reg(offs[i], d, v);
            chk("rvalid", 37'h1, v);
            chk("rdata", e[i] & wm[i], d);
        end
    endtask

    initial begin
        {RST, POWER_ON_RST, MAIN_SUPPLY_PRESENT, SYS_SUPPLY_PRESENT, SYS_SUPPLY_ABOVE_3V1} = 5'b11000;
        repeat (16) @(negedge CORE_CLK);
        {RST, POWER_ON_RST} = 2'b00;
        wait_ready();
        e = fac;
        check_all();
        for (int i = 0; i < 8; i++) begin
            host.wr_reg(offs[i], 8'hff);
            e[i] = e[i] | wm[i];
        end
        host.wr_reg(8'h21, 8'hff);
        host.rd_reg(8'h21, d, v);
        chk("unmapped", 37'h0, d);
        check_all();
        pin_reset();
        e = fac;
        check_all();
        host.prog(16'h1234, {9{8'ha5}}, res);
        chk("bad key", 37'h1, res);
        host.prog(16'h5a3c, {9{8'ha5}}, res);
        chk("accept", 37'h2, res);
        chk("locked", 37'h1, NVM_LOCKED);
        chk("unchanged", fexp(), flds);
        host.prog(16'h5a3c, {9{8'h00}}, res);
        chk("second", 37'h1, res);
        pin_reset();
        for (int i = 0; i < 9; i++) e[i] = (8'ha5 & nm[i]) | (fac[i] & ~nm[i]);
        check_all();
        // Power-on reset wipes the store and its lock; programming refused during load
        @(negedge CORE_CLK);
        {RST, POWER_ON_RST} = 2'b11;
        @(negedge CORE_CLK);
        {RST, POWER_ON_RST} = 2'b00;
        chk("unlocked", 37'h0, NVM_LOCKED);
        host.prog(16'h5a3c, {9{8'h00}}, res);
        chk("during load", 37'h1, res);
        wait_ready();
        e = fac;
        check_all();
        for (int i = 0; i < 8; i++) begin
            @(negedge CORE_CLK);
            {MAIN_SUPPLY_PRESENT, SYS_SUPPLY_PRESENT, SYS_SUPPLY_ABOVE_3V1} = i[2:0];
            repeat (4) @(negedge CORE_CLK);
            chk("supply", i[1] & (i[0] | ~i[2]), SYSTEM_SUPPLY_INPUT_SEL);
        end
        conclude();
    end
endmodule // tb_top
